// File: hdl/imurd_pkg.sv
// Constants and types shared by the inertial burst readout block.
// How it works
// [R1] Master opens a burst with word 0x3E00.
// [R2] Burst sends one 16-bit word per frame.
// [R3] Eleven output words in ascending address order.
// [R4] New-sample flag marks unread register contents.
// [R5] Alarm flag mirrors any diagnostic status bit.
// [R6] Supply sample: 12-bit unsigned, low bits.
// [R7] Rate samples: 14-bit signed, low bits.
// [R8] Rate scale follows the selected range.
// [R9] Acceleration samples: 14-bit signed, low bits.
// [R10] Temperature samples: 12-bit signed, zero at 25C.
// [R11] Auxiliary converter: 12-bit unsigned, low bits.
// [R12] Rate bias: 13-bit signed, top bits zero.
// [R13] Rate bias is added to each rate sample.
// [R14] Rate bias registers reset to zero.
// [R15] Master writes a bias as two bytes.
// [R16] Read command: zero, address, ignored byte.
// [R17] Read answer comes in the following frame.
// [R18] Write command stores low byte at address.
// [R19] Frame after a write returns zero.
// [R20] Flags in bits 15 and 14, sample right-justified.
// [R21] Shifting a word out clears its flag.
// [R22] Chip select rising ends the burst.
package imurd_pkg;
  localparam int WORD_W = 16;
  localparam int RATE_W = 14;
  localparam int BIAS_W = 13;
  localparam int N_OUT = 11;
  localparam int IW = 4;
  localparam int N_BIAS = 3;
  localparam logic [4:0] BIT_LAST = 5'h0f;
  localparam logic [6:0] ADDR_FIRST = 7'h02;
  localparam logic [6:0] ADDR_LAST = 7'h17;
  localparam logic [6:0] ADDR_BIAS_LO = 7'h1a;
  localparam logic [6:0] ADDR_BIAS_HI = 7'h1f;
  localparam logic [6:0] ADDR_BURST = 7'h3e;
  localparam logic [5:0] WORD_FIRST = 6'h01;
  localparam logic [1:0] BIAS_FIRST = 2'h1;
  localparam logic [IW-1:0] IDX_FIRST = 4'h0;
  localparam logic [IW-1:0] IDX_RATE1 = 4'h1;
  localparam logic [IW-1:0] IDX_RATE3 = 4'h3;
  localparam logic [IW-1:0] IDX_ACC3 = 4'h6;
  localparam logic [RATE_W-1:0] MASK14 = 14'h3fff;
  localparam logic [RATE_W-1:0] MASK12 = 14'h0fff;
  localparam logic [BIAS_W-1:0] BIAS_RST = 13'h0000;
  localparam logic [2:0] RANGE_MID = 3'h2;
  localparam logic [2:0] RANGE_NARROW = 3'h1;
  localparam logic [WORD_W-1:0] CMD_BURST = 16'h3e00;

  typedef enum logic [1:0] {
    ST_SINGLE = 2'b01,
    ST_BURST = 2'b10
  } imurd_mode_t;

  typedef enum logic [2:0] {
    SRC_OUT = 3'b001,
    SRC_BIAS = 3'b010,
    SRC_ZERO = 3'b100
  } imurd_src_t;

  typedef struct packed {
    logic [IW-1:0] sel;
    logic [WORD_W-1:0] raw;
  } imurd_smp_t;

  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } imurd_cmd_t;
endpackage

// File: hdl/imurd_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser whose level moves when stages two and three agree.
module imurd_sync #(
  parameter logic INIT = 1'b0
) (
  // Clock and control.
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Pin and filtered level.
  input wire logic async_in,
  output logic level
);
  logic [2:0] sh_ff;
  logic level_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sh_ff <= {3{INIT}};
    end else if (ce) begin
      sh_ff <= {sh_ff[1:0], async_in};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_ff <= INIT;
    end else if (ce && (sh_ff[1] == sh_ff[2])) begin
      level_ff <= sh_ff[2];
    end
  end

  assign level = level_ff;
endmodule

// File: hdl/imurd_mem.sv
`timescale 1ns/1ps
// Sample store with one write port and a registered read port.
module imurd_mem #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 11,
  parameter int AW = 4
) (
  // Clock and control.
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Write port.
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port.
  input wire logic [AW-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] rd_data_ff;

  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("imurd_mem: depth does not fit the index width");
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (ce && wr_en && (wr_idx < AW'(DEPTH))) begin
      mem_ff[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_ff <= '0;
    end else if (ce) begin
      rd_data_ff <= (rd_idx < AW'(DEPTH)) ? mem_ff[rd_idx] : '0;
    end
  end

  assign rd_data = rd_data_ff;
endmodule

// File: hdl/imurd_top.sv
`timescale 1ns/1ps
// Serial slave that returns sample words, bursts all of them and holds rate bias.
module imurd_top
  import imurd_pkg::*;
#(
  parameter int N_WORDS = N_OUT
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Serial link pins.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe_n,
  // Sensor side.
  input wire logic smp_valid,
  input wire imurd_smp_t smp,
  input wire logic [WORD_W-1:0] diag_status,
  input wire logic [2:0] range_sel,
  // Status.
  output logic burst_active
);
  if (N_WORDS < 1 || N_WORDS > N_OUT) begin : g_bad_words
    $error("imurd_top: word count outside the address map");
  end

  // ****************************************
  // Pin synchronisers and edge detection.
  // ****************************************
  logic sclk_s;
  logic cs_n_s;
  logic din_s;
  logic sclk_d_ff;
  logic cs_d_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;

  imurd_sync #(.INIT(1'b1)) u_sync_sclk (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .async_in(sclk),
    .level(sclk_s)
  );

  imurd_sync #(.INIT(1'b1)) u_sync_cs (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .async_in(cs_n),
    .level(cs_n_s)
  );

  imurd_sync #(.INIT(1'b0)) u_sync_din (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .async_in(din),
    .level(din_s)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_d_ff <= 1'b1;
      cs_d_ff <= 1'b1;
    end else if (ce) begin
      sclk_d_ff <= sclk_s;
      cs_d_ff <= cs_n_s;
    end
  end

  assign sclk_rise = ce & sclk_s & ~sclk_d_ff & ~cs_n_s;
  assign sclk_fall = ce & ~sclk_s & sclk_d_ff & ~cs_n_s;
  assign cs_rise = ce & cs_n_s & ~cs_d_ff;

  // ****************************************
  // Receive framing.
  // ****************************************
  logic [4:0] bit_cnt_ff;
  logic [WORD_W-1:0] rx_ff;
  logic [WORD_W-1:0] rx_word;
  logic cmd_take;
  imurd_cmd_t cmd;

  assign rx_word = {rx_ff[WORD_W-2:0], din_s};
  assign cmd = rx_word;
  assign cmd_take = sclk_rise && (bit_cnt_ff == BIT_LAST);

  // [R2] Sixteen-bit frames.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt_ff <= '0;
      rx_ff <= '0;
    end else if (ce) begin
      if (cs_n_s) begin
        bit_cnt_ff <= '0;
      end else if (sclk_rise) begin
        rx_ff <= rx_word;
        if (bit_cnt_ff == BIT_LAST) begin
          bit_cnt_ff <= '0;
        end else begin
          bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
      end
    end
  end

  // ****************************************
  // Command decode and burst sequencing.
  // ****************************************
  imurd_mode_t mode_ff;
  imurd_src_t src_ff;
  logic [IW-1:0] burst_idx_ff;
  logic [IW-1:0] rd_idx_ff;
  logic [IW-1:0] addr_idx;
  logic [IW-1:0] last_idx;
  logic [5:0] word_addr;
  logic addr_out;
  logic addr_bias;

  assign word_addr = cmd.addr[6:1] - WORD_FIRST;
  assign addr_idx = word_addr[IW-1:0];
  assign last_idx = IW'(N_WORDS - 1);
  assign addr_out = (cmd.addr >= ADDR_FIRST) && (cmd.addr <= ADDR_LAST)
                    && (word_addr < 6'(N_WORDS));
  assign addr_bias = (cmd.addr >= ADDR_BIAS_LO) && (cmd.addr <= ADDR_BIAS_HI);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_ff <= ST_SINGLE;
      src_ff <= SRC_ZERO;
      burst_idx_ff <= IDX_FIRST;
      rd_idx_ff <= IDX_FIRST;
    end else if (ce) begin
      if (cs_rise) begin
        // [R22] Chip select ends burst.
        mode_ff <= ST_SINGLE;
      end else if (cmd_take) begin
        if (mode_ff == ST_BURST) begin
          // [R3] Ascending burst order.
          src_ff <= SRC_OUT;
          rd_idx_ff <= burst_idx_ff;
          burst_idx_ff <= burst_idx_ff + 4'h1;
          if (burst_idx_ff == last_idx) begin
            mode_ff <= ST_SINGLE;
          end
        end else if (cmd.wr) begin
          // [R19] Zero after write.
          src_ff <= SRC_ZERO;
        end else if (cmd.addr == ADDR_BURST) begin
          // [R2] Burst start loads first word.
          mode_ff <= ST_BURST;
          src_ff <= SRC_OUT;
          rd_idx_ff <= IDX_FIRST;
          burst_idx_ff <= IDX_FIRST + 4'h1;
        end else if (addr_out) begin
          // [R17] Single read answer.
          src_ff <= SRC_OUT;
          rd_idx_ff <= addr_idx;
        end else if (addr_bias) begin
          src_ff <= SRC_BIAS;
          rd_idx_ff <= IW'(cmd.addr[2:1] - BIAS_FIRST);
        end else begin
          src_ff <= SRC_ZERO;
        end
      end
    end
  end

  // ****************************************
  // Rate bias registers.
  // ****************************************
  logic [BIAS_W-1:0] bias_ff [N_BIAS];
  logic wr_bias;
  logic [1:0] wr_bsel;

  assign wr_bias = cmd_take && (mode_ff == ST_SINGLE) && cmd.wr && addr_bias;
  assign wr_bsel = cmd.addr[2:1] - BIAS_FIRST;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // [R14] Bias clears on reset.
      for (int k = 0; k < N_BIAS; k++) begin
        bias_ff[k] <= BIAS_RST;
      end
    end else if (ce && wr_bias) begin
      for (int k = 0; k < N_BIAS; k++) begin
        if (wr_bsel == 2'(k)) begin
          // [R18] Byte write store.
          if (cmd.addr[0]) begin
            bias_ff[k][BIAS_W-1:8] <= cmd.data[BIAS_W-9:0];
          end else begin
            bias_ff[k][7:0] <= cmd.data;
          end
        end
      end
    end
  end

  // ****************************************
  // Sample intake with bias correction.
  // ****************************************
  logic is_rate;
  logic smp_wr;
  logic [1:0] smp_bsel;
  logic signed [RATE_W-1:0] bias_ext;
  logic signed [RATE_W-1:0] corr;
  logic [RATE_W-1:0] smp_store;
  logic [RATE_W-1:0] rd_data;

  assign is_rate = (smp.sel >= IDX_RATE1) && (smp.sel <= IDX_RATE3);
  assign smp_wr = smp_valid && (smp.sel < IW'(N_WORDS));

  always_comb begin
    smp_bsel = is_rate ? 2'(smp.sel - IDX_RATE1) : 2'h0;
    bias_ext = {{(RATE_W - BIAS_W){bias_ff[smp_bsel][BIAS_W-1]}}, bias_ff[smp_bsel]};
    // [R8] Bias scaled to the range.
    if (range_sel == RANGE_NARROW) begin
      corr = bias_ext;
    end else if (range_sel == RANGE_MID) begin
      corr = bias_ext >>> 1;
    end else begin
      corr = bias_ext >>> 2;
    end
    // [R13] Bias added to rate.
    if (is_rate) begin
      smp_store = smp.raw[RATE_W-1:0] + corr;
    end else begin
      smp_store = smp.raw[RATE_W-1:0];
    end
  end

  imurd_mem #(.WIDTH(RATE_W), .DEPTH(N_WORDS), .AW(IW)) u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .wr_en(smp_wr),
    .wr_idx(smp.sel),
    .wr_data(smp_store),
    .rd_idx(rd_idx_ff),
    .rd_data(rd_data)
  );

  // ****************************************
  // Flags.
  // ****************************************
  logic [1:0] ld_ff;
  logic [N_WORDS-1:0] nd_ff;
  logic ea_ff;
  logic ld_out;

  assign ld_out = ld_ff[1] && (src_ff == SRC_OUT);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ld_ff <= '0;
      ea_ff <= 1'b0;
    end else if (ce) begin
      ld_ff <= {ld_ff[0], cmd_take};
      // [R5] Alarm from diagnostics.
      ea_ff <= |diag_status;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nd_ff <= '0;
    end else if (ce) begin
      for (int k = 0; k < N_WORDS; k++) begin
        if (smp_wr && (smp.sel == IW'(k))) begin
          // [R4] Fresh sample sets flag.
          nd_ff[k] <= 1'b1;
        end else if (ld_out && (rd_idx_ff == IW'(k))) begin
          // [R21] Shifted word clears flag.
          nd_ff[k] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Transmit word build and shifting.
  // ****************************************
  logic [WORD_W-1:0] tx_word_ff;
  logic [WORD_W-1:0] tx_sr_ff;
  logic [RATE_W-1:0] field_mask;
  logic dout_ff;
  logic dout_oe_n_ff;

  // [R6] [R7] [R9] [R10] [R11] Field width by word.
  assign field_mask = (rd_idx_ff >= IDX_RATE1 && rd_idx_ff <= IDX_ACC3) ? MASK14 : MASK12;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_word_ff <= '0;
    end else if (ce && ld_ff[1]) begin
      if (src_ff == SRC_OUT) begin
        // [R20] Flag and field layout.
        tx_word_ff <= {nd_ff[rd_idx_ff], ea_ff, rd_data & field_mask};
      end else if (src_ff == SRC_BIAS) begin
        // [R12] Bias upper bits zero.
        tx_word_ff <= {3'h0, bias_ff[rd_idx_ff[1:0]]};
      end else begin
        tx_word_ff <= '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_sr_ff <= '0;
      dout_ff <= 1'b0;
    end else if (ce && sclk_fall) begin
      if (bit_cnt_ff == 5'h00) begin
        dout_ff <= tx_word_ff[WORD_W-1];
        tx_sr_ff <= {tx_word_ff[WORD_W-2:0], 1'b0};
      end else begin
        dout_ff <= tx_sr_ff[WORD_W-1];
        tx_sr_ff <= {tx_sr_ff[WORD_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dout_oe_n_ff <= 1'b1;
    end else if (ce) begin
      dout_oe_n_ff <= cs_n_s;
    end
  end

  assign dout = dout_ff;
  assign dout_oe_n = dout_oe_n_ff;
  assign burst_active = mode_ff[1];

  // ****************************************
  // Assertions.
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !ce);

  property p_burst_start;
    cmd_take && mode_ff == ST_SINGLE && rx_word == CMD_BURST |=>
      burst_active && rd_idx_ff == IDX_FIRST ##1 ld_ff[1];
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst did not start"); // [R3]

  property p_burst_step;
    cmd_take && mode_ff == ST_BURST |=> rd_idx_ff == $past(burst_idx_ff) && src_ff == SRC_OUT;
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst word out of order"); // [R3]

  property p_shift;
    sclk_fall && bit_cnt_ff != 5'h00 |=> dout == $past(tx_sr_ff[WORD_W-1]);
  endproperty
  a_shift: assert property (p_shift) else $error("serial bit not shifted"); // [R2]

  property p_nd_set;
    smp_wr |=> nd_ff[$past(smp.sel)];
  endproperty
  a_nd_set: assert property (p_nd_set) else $error("new sample flag not set"); // [R4]

  property p_nd_clear;
    ld_out && !(smp_wr && smp.sel == rd_idx_ff) |=> !nd_ff[$past(rd_idx_ff)];
  endproperty
  a_nd_clear: assert property (p_nd_clear) else $error("flag not cleared"); // [R21]

  property p_ea;
    ld_out |=> tx_word_ff[WORD_W-2] == $past(ea_ff);
  endproperty
  a_ea: assert property (p_ea) else $error("alarm flag wrong"); // [R5]

  property p_supply_field;
    ld_out && rd_idx_ff == IDX_FIRST |=> tx_word_ff[13:12] == 2'h0;
  endproperty
  a_supply_field: assert property (p_supply_field) else $error("supply field too wide"); // [R6]

  property p_byte_wr;
    wr_bias && !cmd.addr[0] |=> bias_ff[$past(wr_bsel)][7:0] == $past(cmd.data);
  endproperty
  a_byte_wr: assert property (p_byte_wr) else $error("bias byte not stored"); // [R18]

  property p_read_lat;
    cmd_take && mode_ff == ST_SINGLE && !cmd.wr && addr_out |-> ##2 ld_out;
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read answer not loaded"); // [R17]

  property p_cs_end;
    cs_rise |=> !burst_active;
  endproperty
  a_cs_end: assert property (p_cs_end) else $error("burst survived chip select"); // [R22]

  c_burst_done: cover property (burst_active && cmd_take && burst_idx_ff == last_idx);
  c_bias_write: cover property (wr_bias && cmd.addr[0]);
  c_single_read: cover property (ld_out && !burst_active);
endmodule

// File: testbench/imurd_master.sv
// Serial bus master model that frames command words for the readout block.
`timescale 1ns/1ps
module imurd_master (
  // Link pins.
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe_n
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // Chip select moves with sclk idle high; din is inverted on every select and release.
  task automatic sel(input logic on);
    #400;
    cs_n = ~on;
    din = ~din;
    #800;
  endtask

  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      din = tx[i];
      #400;
      sclk = 1'b1;
      #400;
      rx[i] = dout_oe_n ? 1'bx : dout;
    end
    din = ~din;
    #800;
  endtask
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the inertial burst readout block.
`timescale 1ns/1ps
module tb_top
  import imurd_pkg::*;
();
  logic clk, sys_rst, ce, smp_valid, burst_active, dout, dout_oe_n;
  wire sclk, cs_n, din;
  imurd_smp_t smp;
  logic [15:0] diag_status, rx;
  logic [15:0] raw_m [11];
  logic nd_m [11];
  logic [12:0] bias_m [3];
  logic [2:0] range_sel;
  int error_cnt, checked;

  always #50 clk = ~clk;

  imurd_top #(.N_WORDS(N_OUT)) imurd_top_i (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
    .smp_valid(smp_valid), .smp(smp), .diag_status(diag_status),
    .range_sel(range_sel), .burst_active(burst_active));

  imurd_master imurd_master_i (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe_n(dout_oe_n));

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic [15:0] expw(input int s, input logic [15:0] r,
                                       input logic nd, input logic ea);
    logic signed [13:0] b;
    logic [13:0] f;
    b = 14'h0000;
    if (s >= 1 && s <= 3) b = {bias_m[s-1][12], bias_m[s-1]};
    if (range_sel != RANGE_NARROW) b = b >>> (range_sel == RANGE_MID ? 1 : 2);
    f = (s >= 1 && s <= 6) ? r[13:0] + b : {2'h0, r[11:0]};
    return {nd, ea, f};
  endfunction

  task automatic sel(input logic on);
    imurd_master_i.sel(on);
  endtask

  task automatic fr(input logic [15:0] tx, output logic [15:0] r);
    imurd_master_i.frame(tx, r);
  endtask

  task automatic rda(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] r;
    fr({1'b0, a, 8'h5a}, r);
    fr(16'h0000, r);
    chk(r, e);
  endtask

  task automatic rds(input int s);
    rda(7'(2 + 2 * s), expw(s, raw_m[s], nd_m[s], |diag_status));
    nd_m[s] = 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    fr({1'b1, a, d}, r);
    fr(16'h0000, r);
    chk(r, 16'h0000);
  endtask

  task automatic put(input int s);
    @(negedge clk);
    raw_m[s] = 16'($urandom);
    smp_valid <= 1'b1;
    smp <= '{sel: 4'(s), raw: raw_m[s]};
    nd_m[s] = 1'b1;
    @(negedge clk);
    smp_valid <= 1'b0;
  endtask

  // Burst frames carry a bias write that must be ignored, the last one a read.
  task automatic burst();
    logic [15:0] r;
    sel(1'b1);
    fr(CMD_BURST, r);
    chk({15'h0000, burst_active}, 16'h0001);
    for (int i = 0; i < N_OUT; i++) begin
      fr(i == N_OUT - 1 ? 16'h1a00 : 16'h9b05, r);
      chk(r, expw(i, raw_m[i], nd_m[i], |diag_status));
      nd_m[i] = 1'b0;
    end
    chk({15'h0000, burst_active}, 16'h0000);
    fr(16'h0000, r);
    chk(r, {3'h0, bias_m[0]});
    sel(1'b0);
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    ce = 1'b1;
    smp_valid = 1'b0;
    smp = '0;
    diag_status = 16'h0000;
    range_sel = 3'h4;
    error_cnt = 0;
    checked = 0;
    foreach (nd_m[i]) begin
      nd_m[i] = 1'b0;
      raw_m[i] = 16'h0000;
    end
    foreach (bias_m[i]) bias_m[i] = 13'h0000;
    void'($urandom(32'hc706115f));
    repeat (12) @(posedge clk);
    @(negedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(negedge clk);
    chk({14'h0000, dout_oe_n, burst_active}, 16'h0002);
    sel(1'b1);
    chk({15'h0000, dout_oe_n}, 16'h0000);
    for (int i = 0; i < 3; i++) rda(7'h1a + 7'(2 * i), 16'h0000);
    rda(7'h18, 16'h0000);
    sel(1'b0);
    for (int s = 0; s < N_OUT; s++) put(s);
    burst();
    @(negedge clk);
    diag_status <= 16'h0001 << ($urandom % 16);
    burst();
    sel(1'b1);
    wr(7'h1b, 8'h1f);
    wr(7'h1a, 8'hf6);
    wr(7'h1d, 8'hff);
    bias_m[0] = 13'h1ff6;
    bias_m[1] = 13'h1f00;
    bias_m[2] = 13'($urandom);
    wr(7'h1f, {3'h0, bias_m[2][12:8]});
    wr(7'h1e, bias_m[2][7:0]);
    rda(7'h1b, 16'h1ff6);
    rda(7'h1c, 16'h1f00);
    rda(7'h1e, {3'h0, bias_m[2]});
    sel(1'b0);
    @(negedge clk);
    diag_status <= 16'h0000;
    for (int r = 0; r < 3; r++) begin
      @(negedge clk);
      range_sel <= r == 0 ? 3'h4 : (r == 1 ? RANGE_MID : RANGE_NARROW);
      for (int s = 1; s < 7; s++) put(s);
      sel(1'b1);
      for (int s = 1; s < 7; s++) rds(s);
      sel(1'b0);
    end
    @(negedge clk);
    ce <= 1'b0;
    rx = raw_m[8];
    put(8);
    raw_m[8] = rx;
    nd_m[8] = 1'b0;
    @(negedge clk);
    ce <= 1'b1;
    sel(1'b1);
    rds(8);
    sel(1'b0);
    put(10);
    sel(1'b1);
    fr(CMD_BURST, rx);
    for (int i = 0; i < 3; i++) fr(16'h0000, rx);
    sel(1'b0);
    chk({15'h0000, burst_active}, 16'h0000);
    sel(1'b1);
    rds(10);
    rds(0);
    sel(1'b0);
    test_done();
  end

  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    $display("[FAIL] %0t run did not finish", $time);
    test_done();
  end
endmodule
